//--- logic/aef_frag_engine.sv
/*
 * Acknowledged fragmentation engine for explicit messages over CAN frames:
 * transmitter that fragments and retries, receiver that reassembles and acks.
 * Assumes a CAN controller with valid/ready frame ports and an application
 * that streams message bytes and reads reassembled messages by address.
 */
`timescale 1ns/100ps
`default_nettype none
module aef_frag_engine #(
    parameter int LEN_W = 16,
    parameter int RX_DEPTH = 64,
    parameter int TMR_W = 24
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Configuration
    input wire logic [aef_pkg::NODE_W-1:0] node_address_i,
    input wire logic [TMR_W-1:0] ack_timeout_i,
    // Application transmit
    input wire logic app_send_i,
    input wire logic [LEN_W-1:0] app_len_i,
    input wire logic app_tag_i,
    input wire logic app_byte_valid_i,
    input wire logic [7:0] app_byte_i,
    output logic app_byte_ready_o,
    output logic tx_busy_o,
    output logic tx_done_o,
    output logic tx_error_o,
    // CAN controller transmit
    output logic can_tx_valid_o,
    output logic [63:0] can_tx_data_o,
    output logic [3:0] can_tx_dlc_o,
    input wire logic can_tx_ready_i,
    // CAN controller receive
    input wire logic can_rx_valid_i,
    input wire logic [63:0] can_rx_data_i,
    input wire logic [3:0] can_rx_dlc_i,
    output logic can_rx_ready_o,
    // Application receive
    output logic rx_msg_valid_o,
    output logic [$clog2(RX_DEPTH):0] rx_msg_len_o,
    output logic [7:0] rx_msg_hdr_o,
    input wire logic [$clog2(RX_DEPTH)-1:0] rx_rd_addr_i,
    output logic [7:0] rx_rd_data_o
);
    localparam int AW = $clog2(RX_DEPTH);

    generate
        if (RX_DEPTH < aef_pkg::PLAIN_BODY || LEN_W < 4 || TMR_W < 2) begin : g_bad_param
            $error("aef_frag_engine: unsupported parameter values");
        end
    endgenerate

    typedef struct packed {
        aef_pkg::aef_tx_st_t tst;
        logic frag;
        logic first;
        logic retried;
        logic [7:0] hdr;
        logic [LEN_W-1:0] rem;
        logic [2:0] fill;
        logic [aef_pkg::SEQ_W-1:0] tcnt;
        logic [63:0] tfr;
        logic [3:0] tdlc;
        logic byte_rdy;
        logic done;
        logic err;
        logic busy;
        aef_pkg::aef_rx_st_t rst;
        logic [aef_pkg::SEQ_W-1:0] rcnt;
        logic [AW:0] wp;
        logic [RX_DEPTH-1:0][7:0] mem;
        logic ack_pend;
        logic [23:0] afr;
        logic dlv_pend;
        logic msg_v;
        logic [AW:0] mlen;
        logic [7:0] mhdr;
        logic [7:0] rd;
        logic rx_rdy;
        logic ov;
        logic oack;
        logic [63:0] odat;
        logic [3:0] odlc;
    } aef_eng_state_t;

    aef_eng_state_t s;
    aef_eng_state_t next_s;
    logic [1:0] rsync;
    logic rst_n;

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rsync <= 2'h0;
        end else begin
            rsync <= {rsync[0], 1'b1};
        end
    end
    assign rst_n = rsync[1];

    aef_tmr_if #(.W(TMR_W)) tmr_if ();

    aef_ack_timer #(.TMR_W(TMR_W)) u_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .tmr(tmr_if.tmr)
    );

    // Incoming frame decode
    logic rx_take;
    logic rx_frag;
    logic [1:0] rx_ft;
    logic [aef_pkg::SEQ_W-1:0] rx_cnt;
    logic [7:0] rx_ctrl;
    logic rx_is_ack;
    logic ack_hit;
    assign rx_take = can_rx_valid_i && s.rx_rdy;
    assign rx_frag = can_rx_data_i[8*aef_pkg::HDR_BYTE + aef_pkg::HDR_FRAG_BIT];
    assign rx_ctrl = can_rx_data_i[8*aef_pkg::CTRL_BYTE +: 8];
    assign rx_ft = rx_ctrl[aef_pkg::FT_LO +: 2];
    assign rx_cnt = rx_ctrl[aef_pkg::CNT_LO +: aef_pkg::SEQ_W];
    assign rx_is_ack = rx_frag && rx_ft == aef_pkg::FT_ACK;
    assign ack_hit = rx_take && rx_is_ack && s.tst == aef_pkg::TX_WAIT
        && rx_cnt == s.tcnt;

    // Timer runs from the moment the fragment leaves
    assign tmr_if.start = s.ov && can_tx_ready_i && !s.oack && s.frag
        && s.tst == aef_pkg::TX_WAIT;
    assign tmr_if.stop = ack_hit;
    assign tmr_if.load = ack_timeout_i;

    always_comb begin
        int body;
        int ofs;
        logic wr_en;
        logic [7:0] ctrl;
        logic [7:0] stat;
        logic [1:0] ft;
        logic [AW:0] idx;
        body = 0;
        ofs = aef_pkg::FRAG_BODY_OFS;
        wr_en = 1'b0;
        ctrl = '0;
        stat = aef_pkg::ACK_OK;
        ft = aef_pkg::FT_FIRST;
        idx = '0;
        next_s = s;
        next_s.done = 1'b0;
        next_s.err = 1'b0;
        next_s.msg_v = 1'b0;

        // Output slot; acks go ahead of data fragments
        if (s.ov && can_tx_ready_i) begin
            next_s.ov = 1'b0;
        end
        if (!next_s.ov && s.ack_pend) begin
            next_s.ov = 1'b1;
            next_s.oack = 1'b1;
            next_s.odat = 64'(s.afr);
            next_s.odlc = aef_pkg::ACK_DLC;
            next_s.ack_pend = 1'b0;
            if (s.dlv_pend) begin
                next_s.msg_v = 1'b1;
                next_s.dlv_pend = 1'b0;
            end
        end

        // Transmitter
        case (s.tst)
            aef_pkg::TX_IDLE: begin
                if (app_send_i) begin
                    next_s.frag = app_len_i > LEN_W'(aef_pkg::PLAIN_BODY);
                    next_s.hdr = '0;
                    next_s.hdr[aef_pkg::HDR_FRAG_BIT] = next_s.frag;
                    next_s.hdr[aef_pkg::HDR_TAG_BIT] = app_tag_i;
                    next_s.hdr[aef_pkg::NODE_LO +: aef_pkg::NODE_W] = node_address_i;
                    next_s.tfr = '0;
                    next_s.tfr[8*aef_pkg::HDR_BYTE +: 8] = next_s.hdr;
                    next_s.rem = app_len_i;
                    next_s.tcnt = aef_pkg::SEQ_FIRST;
                    next_s.first = 1'b1;
                    next_s.retried = 1'b0;
                    next_s.fill = '0;
                    next_s.tst = aef_pkg::TX_FILL;
                end
            end
            aef_pkg::TX_FILL: begin
                ofs = s.frag ? aef_pkg::FRAG_BODY_OFS : aef_pkg::PLAIN_BODY_OFS;
                if (app_byte_valid_i && s.byte_rdy) begin
                    next_s.tfr[8*(int'(s.fill) + ofs) +: 8] = app_byte_i;
                    next_s.fill = s.fill + 3'h1;
                    next_s.rem = s.rem - LEN_W'(1);
                end
                if (next_s.rem == '0
                    || int'(next_s.fill) == (s.frag ? aef_pkg::FRAG_BODY : aef_pkg::PLAIN_BODY)) begin
                    if (s.frag) begin
                        if (s.first) begin
                            ft = aef_pkg::FT_FIRST;
                        end else if (next_s.rem == '0) begin
                            ft = aef_pkg::FT_LAST;
                        end else begin
                            ft = aef_pkg::FT_MIDDLE;
                        end
                        ctrl[aef_pkg::FT_LO +: 2] = ft;
                        ctrl[aef_pkg::CNT_LO +: aef_pkg::SEQ_W] = s.tcnt;
                        next_s.tfr[8*aef_pkg::CTRL_BYTE +: 8] = ctrl;
                    end
                    next_s.tdlc = 4'(int'(next_s.fill) + ofs);
                    next_s.tst = aef_pkg::TX_SEND;
                end
            end
            aef_pkg::TX_SEND: begin
                if (!next_s.ov) begin
                    next_s.ov = 1'b1;
                    next_s.oack = 1'b0;
                    next_s.odat = s.tfr;
                    next_s.odlc = s.tdlc;
                    if (s.frag) begin
                        next_s.tst = aef_pkg::TX_WAIT;
                    end else begin
                        next_s.done = 1'b1;
                        next_s.tst = aef_pkg::TX_IDLE;
                    end
                end
            end
            aef_pkg::TX_WAIT: begin
                if (ack_hit) begin
                    next_s.retried = 1'b0;
                    next_s.first = 1'b0;
                    if (can_rx_data_i[8*aef_pkg::STAT_BYTE +: 8] != aef_pkg::ACK_OK) begin
                        next_s.err = 1'b1;
                        next_s.tst = aef_pkg::TX_IDLE;
                    end else if (s.rem == '0) begin
                        next_s.done = 1'b1;
                        next_s.tst = aef_pkg::TX_IDLE;
                    end else begin
                        next_s.tcnt = s.tcnt + aef_pkg::SEQ_STEP;
                        next_s.fill = '0;
                        next_s.tst = aef_pkg::TX_FILL;
                    end
                end else if (tmr_if.expire) begin
                    if (!s.retried) begin
                        next_s.retried = 1'b1;
                        next_s.tst = aef_pkg::TX_SEND;
                    end else begin
                        next_s.err = 1'b1;
                        next_s.tst = aef_pkg::TX_IDLE;
                    end
                end
            end
            default: begin
                next_s.tst = aef_pkg::TX_IDLE;
            end
        endcase

        // Receiver; ack frames belong to the transmitter
        if (rx_take && !rx_is_ack) begin
            if (!rx_frag) begin
                ofs = aef_pkg::PLAIN_BODY_OFS;
                body = int'(can_rx_dlc_i) > ofs ? int'(can_rx_dlc_i) - ofs : 0;
                wr_en = 1'b1;
                next_s.wp = '0;
                next_s.mlen = (AW+1)'(body);
                next_s.mhdr = can_rx_data_i[8*aef_pkg::HDR_BYTE +: 8];
                next_s.msg_v = 1'b1;
                next_s.rst = aef_pkg::RX_IDLE;
            end else begin
                // Transmit fill may have moved the shared offset
                ofs = aef_pkg::FRAG_BODY_OFS;
                body = int'(can_rx_dlc_i) > ofs ? int'(can_rx_dlc_i) - ofs : 0;
                if (rx_ft == aef_pkg::FT_FIRST) begin
                    if (rx_cnt == aef_pkg::SEQ_FIRST) begin
                        // Also restarts a series in progress
                        wr_en = 1'b1;
                        next_s.wp = '0;
                        next_s.ack_pend = 1'b1;
                        next_s.rcnt = rx_cnt;
                        next_s.rst = aef_pkg::RX_SERIES;
                    end else begin
                        next_s.rst = aef_pkg::RX_IDLE;
                    end
                end else if (s.rst == aef_pkg::RX_IDLE) begin
                    next_s.rst = aef_pkg::RX_IDLE;
                end else if (rx_cnt == s.rcnt + aef_pkg::SEQ_STEP) begin
                    next_s.ack_pend = 1'b1;
                    next_s.rcnt = rx_cnt;
                    if (int'(s.wp) + body > RX_DEPTH) begin
                        stat = aef_pkg::ACK_TOO_MUCH;
                        next_s.rst = aef_pkg::RX_IDLE;
                    end else begin
                        wr_en = 1'b1;
                        if (rx_ft == aef_pkg::FT_LAST) begin
                            next_s.dlv_pend = 1'b1;
                            next_s.mlen = s.wp + (AW+1)'(body);
                            next_s.mhdr = can_rx_data_i[8*aef_pkg::HDR_BYTE +: 8];
                            next_s.rst = aef_pkg::RX_IDLE;
                        end
                    end
                end else if (rx_cnt == s.rcnt) begin
                    next_s.ack_pend = 1'b1;
                end else begin
                    next_s.rst = aef_pkg::RX_IDLE;
                end
                ctrl[aef_pkg::FT_LO +: 2] = aef_pkg::FT_ACK;
                ctrl[aef_pkg::CNT_LO +: aef_pkg::SEQ_W] = rx_cnt;
                next_s.afr = {stat, ctrl, can_rx_data_i[8*aef_pkg::HDR_BYTE +: 8]};
            end
        end

        // Body bytes into the reassembly buffer
        for (int k = 0; k < aef_pkg::FRAME_BYTES; k++) begin
            if (wr_en && k >= ofs && k < ofs + body) begin
                idx = next_s.wp + (AW+1)'(k - ofs);
                next_s.mem[idx[AW-1:0]] = can_rx_data_i[8*k +: 8];
            end
        end
        if (wr_en) begin
            next_s.wp = next_s.wp + (AW+1)'(body);
        end

        next_s.rd = s.mem[rx_rd_addr_i];
        next_s.rx_rdy = !next_s.ack_pend;
        next_s.busy = next_s.tst != aef_pkg::TX_IDLE;
        next_s.byte_rdy = next_s.tst == aef_pkg::TX_FILL && next_s.rem != '0
            && int'(next_s.fill) < (next_s.frag ? aef_pkg::FRAG_BODY : aef_pkg::PLAIN_BODY);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign app_byte_ready_o = s.byte_rdy;
    assign tx_busy_o = s.busy;
    assign tx_done_o = s.done;
    assign tx_error_o = s.err;
    assign can_tx_valid_o = s.ov;
    assign can_tx_data_o = s.odat;
    assign can_tx_dlc_o = s.odlc;
    assign can_rx_ready_o = s.rx_rdy;
    assign rx_msg_valid_o = s.msg_v;
    assign rx_msg_len_o = s.mlen;
    assign rx_msg_hdr_o = s.mhdr;
    assign rx_rd_data_o = s.rd;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n);

    sequence ack_out;
        can_tx_valid_o && s.oack;
    endsequence
    sequence frag_out;
        can_tx_valid_o && !s.oack && s.frag;
    endsequence
    sequence timeout_hit;
        s.tst == aef_pkg::TX_WAIT && tmr_if.expire && !ack_hit;
    endsequence
    sequence series_take;
        rx_take && rx_frag && !rx_is_ack && s.rst == aef_pkg::RX_SERIES
            && rx_ft != aef_pkg::FT_FIRST;
    endsequence

    a_ack_type_field: assert property (ack_out |->
        can_tx_data_o[8*aef_pkg::CTRL_BYTE + aef_pkg::FT_LO +: 2] == aef_pkg::FT_ACK)
        else $error("ack frame without ack type");
    a_ack_status_legal: assert property (ack_out |->
        can_tx_data_o[8*aef_pkg::STAT_BYTE +: 8] <= aef_pkg::ACK_TOO_MUCH)
        else $error("reserved ack status sent");
    a_frag_header_same: assert property (frag_out |->
        can_tx_data_o[8*aef_pkg::HDR_BYTE +: 8] == s.hdr && s.hdr[aef_pkg::HDR_FRAG_BIT])
        else $error("fragment header differs");
    a_ctrl_count_kept: assert property (frag_out |->
        can_tx_data_o[8*aef_pkg::CTRL_BYTE + aef_pkg::CNT_LO +: aef_pkg::SEQ_W] == s.tcnt)
        else $error("fragment count not retained");
    a_first_retry: assert property (timeout_hit and !s.retried |=>
        s.tst == aef_pkg::TX_SEND && s.retried && !tx_error_o)
        else $error("first timeout did not resend");
    a_second_abort: assert property (timeout_hit and s.retried |=>
        tx_error_o && s.tst == aef_pkg::TX_IDLE)
        else $error("second timeout did not abort");
    a_ack_mismatch_wait: assert property (s.tst == aef_pkg::TX_WAIT && rx_take
        && rx_is_ack && rx_cnt != s.tcnt && !tmr_if.expire |=> s.tst == aef_pkg::TX_WAIT)
        else $error("mismatching ack changed state");
    a_idle_drop_silent: assert property (rx_take && rx_frag && !rx_is_ack
        && s.rst == aef_pkg::RX_IDLE && rx_ft != aef_pkg::FT_FIRST |=> !s.ack_pend
        && s.rst == aef_pkg::RX_IDLE)
        else $error("idle receiver acked a non-first fragment");
    a_series_append: assert property (series_take and rx_cnt == s.rcnt + aef_pkg::SEQ_STEP
        |=> s.ack_pend && s.rcnt == $past(rx_cnt) ##1 can_tx_valid_o && s.oack)
        else $error("next fragment not stored and acked");
    a_bad_count_reset: assert property (series_take and rx_cnt != s.rcnt
        && rx_cnt != s.rcnt + aef_pkg::SEQ_STEP |=> !s.ack_pend && s.rst == aef_pkg::RX_IDLE)
        else $error("bad count not discarded");
endmodule // aef_frag_engine
`default_nettype wire

//--- include/aef_pkg.sv
/*
 * Shared constants and types of the acknowledged fragmentation engine:
 * frame field layout, fragment types, ack status codes and state enums.
 * Assumes CAN frames of up to eight data bytes, byte k at bits 8k+7..8k.
 */
package aef_pkg;
    localparam int FRAME_BYTES = 8;
    localparam int SEQ_W = 6;
    localparam int NODE_W = 6;
    // Header byte layout
    localparam int HDR_BYTE = 0;
    localparam int HDR_FRAG_BIT = 7;
    localparam int HDR_TAG_BIT = 6;
    localparam int NODE_LO = 0;
    // Fragmentation control byte layout and ack status byte
    localparam int CTRL_BYTE = 1;
    localparam int FT_LO = 6;
    localparam int CNT_LO = 0;
    localparam int STAT_BYTE = 2;
    // First body byte of a fragment and of a plain message
    localparam int FRAG_BODY_OFS = 2;
    localparam int PLAIN_BODY_OFS = 1;
    // Body bytes per frame
    localparam int FRAG_BODY = 6;
    localparam int PLAIN_BODY = 7;
    localparam logic [1:0] FT_FIRST = 2'h0;
    localparam logic [1:0] FT_MIDDLE = 2'h1;
    localparam logic [1:0] FT_LAST = 2'h2;
    localparam logic [1:0] FT_ACK = 2'h3;
    localparam logic [7:0] ACK_OK = 8'h00;
    localparam logic [7:0] ACK_TOO_MUCH = 8'h01;
    localparam logic [3:0] ACK_DLC = 4'h3;
    localparam logic [SEQ_W-1:0] SEQ_FIRST = 6'h00;
    localparam logic [SEQ_W-1:0] SEQ_STEP = 6'h01;

    typedef enum logic [1:0] {TX_IDLE, TX_FILL, TX_SEND, TX_WAIT} aef_tx_st_t;
    typedef enum logic {RX_IDLE, RX_SERIES} aef_rx_st_t;
endpackage

//--- include/aef_tmr_if.sv
/*
 * Control link between the fragment engine and its acknowledgement timer.
 * Assumes both ends share one clock; start and stop are one-cycle pulses.
 */
`timescale 1ns/100ps
`default_nettype none
interface aef_tmr_if #(parameter int W = 24) ();
    logic start;
    logic stop;
    logic [W-1:0] load;
    logic expire;
    modport ctl (output start, output stop, output load, input expire);
    modport tmr (input start, input stop, input load, output expire);
endinterface
`default_nettype wire

//--- logic/aef_ack_timer.sv
/*
 * Acknowledgement wait timer: loads a cycle count on start, pulses expire
 * when it runs out. Assumes a synchronised active-low reset from the top.
 */
`timescale 1ns/100ps
`default_nettype none
module aef_ack_timer #(
    parameter int TMR_W = 24
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control from the engine
    aef_tmr_if.tmr tmr
);
    generate
        if (TMR_W < 2) begin : g_bad_width
            $error("aef_ack_timer: TMR_W too small");
        end
    endgenerate

    typedef struct packed {
        logic [TMR_W-1:0] cnt;
        logic run;
        logic exp;
    } aef_tmr_state_t;

    aef_tmr_state_t s;
    aef_tmr_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.exp = 1'b0;
        if (tmr.stop) begin
            next_s.run = 1'b0;
        end else if (tmr.start) begin
            // A zero timeout still waits one cycle
            next_s.cnt = (tmr.load == '0) ? TMR_W'(1) : tmr.load;
            next_s.run = 1'b1;
        end else if (s.run) begin
            if (s.cnt <= TMR_W'(1)) begin
                next_s.run = 1'b0;
                next_s.exp = 1'b1;
            end else begin
                next_s.cnt = s.cnt - TMR_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tmr.expire = s.exp;

    a_timer_arms: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        tmr.start && !tmr.stop |=> s.run && !tmr.expire)
        else $error("wait timer not running after start");
    a_timer_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !s.run && !tmr.start |=> !s.exp)
        else $error("wait timer expired while idle");
endmodule // aef_ack_timer
`default_nettype wire

//--- test/aef_peer.sv
/* Peer node model: CAN controller face of a remote node.
   Assumes one clock; the bench queues frames through put_frame. */
`timescale 1ns/100ps
`default_nettype none
module aef_peer (
    // Clock
    input wire logic ref_clk_i,
    // Frames from the engine
    input wire logic can_tx_valid_i,
    input wire logic [63:0] can_tx_data_i,
    input wire logic [3:0] can_tx_dlc_i,
    output logic can_tx_ready_o,
    // Frames to the engine
    output logic can_rx_valid_o,
    output logic [63:0] can_rx_data_o,
    output logic [3:0] can_rx_dlc_o,
    input wire logic can_rx_ready_i
);
    logic [67:0] seen[$];
    initial begin
        can_tx_ready_o = 1'b1;
        can_rx_valid_o = 1'b0;
        can_rx_data_o = 64'h0000_0000_0000_0000;
        can_rx_dlc_o = 4'h0;
    end
    always @(posedge ref_clk_i) begin
        if (can_tx_valid_i && can_tx_ready_o) begin
            seen.push_back({can_tx_dlc_i, can_tx_data_i});
        end
    end
    // Held until taken, then inverted so stale data never looks valid
    task automatic put_frame(input logic [3:0] dlc, input logic [63:0] d);
        @(negedge ref_clk_i);
        can_rx_valid_o = 1'b1;
        can_rx_data_o = d;
        can_rx_dlc_o = dlc;
        while (!can_rx_ready_i) @(negedge ref_clk_i);
        @(negedge ref_clk_i);
        can_rx_valid_o = 1'b0;
        can_rx_data_o = ~d;
        can_rx_dlc_o = ~dlc;
    endtask
endmodule // aef_peer
`default_nettype wire

//--- test/test_acked_explicit_fragmentation.sv
/* Bench of the fragmentation engine against one peer node model.
   Assumes the engine contract of a 125 MHz clock and ready handshakes. */
`timescale 1ns/100ps
`default_nettype none
module test_acked_explicit_fragmentation;
    localparam logic [7:0] HDR = 8'hd5;
    logic ref_clk_i, resetn_i, app_send_i, app_byte_valid_i, app_byte_ready_o, busy;
    logic [5:0] ra;
    logic tx_error_o, tx_done_o, can_tx_valid_o, can_tx_ready_i;
    logic can_rx_valid_i, can_rx_ready_o, rx_msg_valid_o;
    logic [15:0] app_len_i;
    logic [7:0] app_byte_i, nb, mh, rdd;
    logic [63:0] can_tx_data_o, can_rx_data_i;
    logic [3:0] can_tx_dlc_o, can_rx_dlc_i;
    logic [6:0] rx_msg_len_o;
    logic [67:0] f, g;
    int fails, num_checks, n_err, n_done, n_msg;
    aef_frag_engine u_aef_frag_engine (.ref_clk_i, .resetn_i, .node_address_i(6'h15),
        .ack_timeout_i(24'h00_0014), .app_send_i, .app_len_i, .app_tag_i(1'b1),
        .app_byte_valid_i, .app_byte_i, .app_byte_ready_o, .tx_busy_o(busy), .tx_done_o,
        .tx_error_o, .can_tx_valid_o, .can_tx_data_o, .can_tx_dlc_o, .can_tx_ready_i,
        .can_rx_valid_i, .can_rx_data_i, .can_rx_dlc_i, .can_rx_ready_o, .rx_msg_valid_o,
        .rx_msg_len_o, .rx_msg_hdr_o(mh), .rx_rd_addr_i(ra), .rx_rd_data_o(rdd));
    aef_peer u_aef_peer (.ref_clk_i, .can_tx_valid_i(can_tx_valid_o),
        .can_tx_data_i(can_tx_data_o), .can_tx_dlc_i(can_tx_dlc_o),
        .can_tx_ready_o(can_tx_ready_i), .can_rx_valid_o(can_rx_valid_i),
        .can_rx_data_o(can_rx_data_i), .can_rx_dlc_o(can_rx_dlc_i),
        .can_rx_ready_i(can_rx_ready_o));
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        nb <= !resetn_i ? 8'h00 : nb + ((app_byte_valid_i && app_byte_ready_o) ? 8'h01 : 8'h00);
        n_err <= n_err + int'(tx_error_o === 1'b1);
        n_done <= n_done + int'(tx_done_o === 1'b1);
        n_msg <= n_msg + int'(rx_msg_valid_o === 1'b1);
    end
    always @(negedge ref_clk_i) app_byte_i <= nb;
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic get_tx(output logic [67:0] fr);
        repeat (80) if (u_aef_peer.seen.size() == 0) @(negedge ref_clk_i);
        chk("frame out", 1, u_aef_peer.seen.size() != 0);
        fr = (u_aef_peer.seen.size() != 0) ? u_aef_peer.seen.pop_front() : '0;
    endtask
    task automatic no_tx();
        repeat (40) @(negedge ref_clk_i);
        chk("frames out", 0, u_aef_peer.seen.size());
    endtask
    // Fragment with a fixed six byte body pattern
    task automatic frag(input logic [1:0] ft, input logic [5:0] c, input logic [3:0] dlc);
        u_aef_peer.put_frame(dlc, {48'h0605_0403_0201, ft, c, HDR});
    endtask
    task automatic ack(input logic [5:0] c, input logic [7:0] st = 8'h00);
        get_tx(f);
        chk("ack dlc", 3, f[67:64]);
        chk("ack hdr", HDR, f[7:0]);
        chk("ack ctrl", {2'h3, c}, f[15:8]);
        chk("ack status", st, f[23:16]);
    endtask
    task automatic send(input logic [15:0] l);
        @(negedge ref_clk_i);
        app_send_i = 1'b1;
        app_len_i = l;
        @(negedge ref_clk_i);
        app_send_i = 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        stop_test();
    end
    initial begin
        {resetn_i, app_send_i, app_byte_valid_i} = '0;
        ra = 6'h0d;
        app_len_i = 16'h0000;
        repeat (8) @(negedge ref_clk_i);
        resetn_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        app_byte_valid_i = 1'b1;
        frag(2'h1, 6'h01, 4'h8);
        no_tx();
        frag(2'h0, 6'h00, 4'h8);
        ack(6'h00);
        frag(2'h1, 6'h05, 4'h8);
        no_tx();
        frag(2'h1, 6'h01, 4'h8);
        no_tx();
        frag(2'h0, 6'h00, 4'h8);
        ack(6'h00);
        frag(2'h1, 6'h01, 4'h8);
        ack(6'h01);
        frag(2'h1, 6'h01, 4'h8);
        ack(6'h01);
        frag(2'h2, 6'h02, 4'h4);
        ack(6'h02);
        chk("msg count", 1, n_msg);
        chk("msg len", 14, rx_msg_len_o);
        chk("msg hdr", HDR, mh);
        chk("msg byte 13", 8'h02, rdd);
        ra = 6'h00;
        u_aef_peer.put_frame(4'h3, {40'h00_0000_0000, 16'hbbaa, 8'h15});
        repeat (2) @(negedge ref_clk_i);
        chk("plain msg count", 2, n_msg);
        chk("plain msg len", 2, rx_msg_len_o);
        chk("plain msg hdr", 8'h15, mh);
        chk("plain msg byte 0", 8'haa, rdd);
        send(16'h0003);
        get_tx(f);
        chk("plain frame", {4'h4, 32'h0201_0055}, {f[67:64], f[31:0]});
        send(16'h0008);
        get_tx(f);
        chk("frag dlc", 8, f[67:64]);
        chk("tx busy", 1, busy);
        chk("frag head", {48'h0807_0605_0403, 16'h00d5}, f[63:0]);
        get_tx(g);
        chk("resent frag", f, g);
        repeat (30) @(negedge ref_clk_i);
        chk("tx errors", 1, n_err);
        chk("tx busy", 0, busy);
        send(16'h0008);
        get_tx(f);
        u_aef_peer.put_frame(4'h3, {40'h00_0000_0000, 8'h00, 8'hc5, HDR});
        u_aef_peer.put_frame(4'h3, {40'h00_0000_0000, 8'h00, 8'hc0, HDR});
        get_tx(g);
        chk("next frag", {4'h4, 16'h81d5}, {g[67:64], g[15:0]});
        u_aef_peer.put_frame(4'h3, {40'h00_0000_0000, 8'h00, 8'hc1, HDR});
        repeat (5) @(negedge ref_clk_i);
        // The plain send above pulsed done as well
        chk("tx done", 2, n_done);
        // Eleven full fragments exceed the reassembly buffer
        frag(2'h0, 6'h00, 4'h8);
        ack(6'h00);
        for (int i = 1; i < 11; i++) begin
            frag(2'h1, 6'(i), 4'h8);
            ack(6'(i), (i == 10) ? 8'h01 : 8'h00);
        end
        stop_test();
    end
endmodule // test_acked_explicit_fragmentation
`default_nettype wire
